// ---- design/asr_pkg.sv ----
// Purpose: shared constants and types of the async serial register block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   printed offsets are indexes, byte address is four times the index
package asr_pkg;
  localparam logic [2:0] IDX_BAUD_HIGH = 3'h0;
  localparam logic [2:0] IDX_BAUD_LOW  = 3'h1;
  localparam logic [2:0] IDX_CTRL_ONE  = 3'h2;
  localparam logic [2:0] IDX_CTRL_TWO  = 3'h3;
  localparam logic [2:0] IDX_STAT_ONE  = 3'h4;
  localparam logic [2:0] IDX_STAT_TWO  = 3'h5;
  localparam logic [2:0] IDX_DATA_HIGH = 3'h6;
  localparam logic [2:0] IDX_DATA_LOW  = 3'h7;
  localparam int         ADDR_LSB      = 2;
  localparam int         DIV_W         = 13;
  localparam int         OVERSAMPLE    = 16;
  localparam logic [4:0] BAUD_HIGH_MASK = 5'h1F;
  localparam logic [12:0] DIV_RESET    = 13'h0004;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  // control one bit positions
  localparam int CR1_LOOP   = 7;
  localparam int CR1_RECEIVE_SOURCE_SELECT   = 5;
  localparam int CR1_NINE   = 4;
  localparam int CR1_PAR_ON = 1;
  localparam int CR1_PAR_OD = 0;
  // control two bit positions
  localparam int CR2_TX_ON  = 3;
  localparam int CR2_RX_ON  = 2;
  // status two / data high bit positions
  localparam int SR2_TXDIR  = 1;
  localparam int DRH_T8     = 6;
  localparam int DRH_R8     = 7;

  typedef struct packed {
    logic       loop_select;
    logic       receive_source_select;
    logic       nine_bits;
    logic       parity_on;
    logic       parity_odd_select;
    logic       transmitter_on;
    logic       receiver_on;
  } asr_cfg_t;
endpackage

// ---- design/asr_regs.sv ----
// Purpose: register file and bit-rate generator of an async serial port
// Assumes: apb slave, zero-wait answers, one module clock pclk
// Notes:   shifter logic lives elsewhere; this block exposes config and ticks
//
// Functional notes
// - bit rate is clock over sixteen times divisor
// - divisor is thirteen bits across two registers
// - high write held until low write
// - high readback may lag until low written
// - generator stopped until first enable after reset
// - generator stopped while divisor is zero
// - reserved writes ignored, reserved reads zero
// - eight registers at offsets zero to seven
// - address is base plus four times offset
// - transmitter and receiver share one generator
// - eight or nine data bits selectable
// - receiver sees sixteenth-bit sample ticks
// - same behaviour in every chip mode
// - one output pin, one input pin
// - loop source selects internal or pin
// - format bit selects nine data bits
// - parity even or odd per select bit
// - transmitter enable gives port the pin
module asr_regs
  import asr_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  status_one_in,
  input  wire logic        rx_pin,
  input  wire logic        tx_serial,
  input  wire logic        rx_bit9,
  input  wire logic [7:0]  rx_byte,
  output logic             tx_pin,
  output logic             tx_pin_oe,
  output logic             rx_serial,
  output logic             sample_tick,
  output logic             bit_tick,
  output logic [8:0]       tx_word,
  output logic             tx_word_load,
  output logic             rx_word_read,
  output logic             tx_parity_even,
  output asr_cfg_t         cfg
);
  // register, generator and decode state
  logic [4:0]           baud_hold_ff;
  logic [DIV_WIDTH-1:0] divisor_value_ff;
  logic [7:0]           control_one_ff;
  logic [7:0]           control_two_ff;
  logic [2:0]           status_two_ff;
  logic                 t8_ff;
  logic                 gen_armed_ff;
  logic [DIV_WIDTH-1:0] div_cnt_ff;
  logic [3:0]           os_cnt_ff;
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 acc_setup;
  logic [2:0]           idx;
  logic                 in_map;
  logic                 gen_run;
  logic                 div_wrap;
  logic                 any_enable;
  logic [31:0]          nxt_prdata;
  logic                 nxt_rx_serial;

  // one decode helper for every register strobe, so all of them agree
  function automatic logic reg_hit(
    input logic       access,
    input logic [2:0] at,
    input logic [2:0] want
  );
    return access && (at == want);
  endfunction

  // address decode, the module base is stripped by the system decoder
  assign idx    = paddr[ADDR_LSB+2:ADDR_LSB];
  assign in_map = (paddr[31:ADDR_LSB+3] == '0) && (paddr[1:0] == 2'h0);

  // bus phases; a low clock enable freezes the bus as well
  assign acc_setup = psel && !penable && clk_en;
  assign acc_wr    = psel && penable && pwrite && clk_en && in_map;
  assign acc_rd    = psel && penable && !pwrite && clk_en && in_map;

  // high byte waits in a holding stage until the low byte arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_hold_ff <= DIV_RESET[12:8];
    end else if (reg_hit(acc_wr, idx, IDX_BAUD_HIGH)) begin
      baud_hold_ff <= pwdata[4:0] & BAUD_HIGH_MASK;
    end
  end

  // divisor moves as one word, so the generator never sees half a value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_value_ff <= DIV_RESET;
    end else if (reg_hit(acc_wr, idx, IDX_BAUD_LOW)) begin
      divisor_value_ff <= {baud_hold_ff, pwdata[7:0]};
    end
  end

  // control one: loop, source, format and parity selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_one_ff <= CTRL_RESET;
    end else if (reg_hit(acc_wr, idx, IDX_CTRL_ONE)) begin
      control_one_ff <= pwdata[7:0];
    end
  end

  // control two: transmitter and receiver enables among others
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_two_ff <= CTRL_RESET;
    end else if (reg_hit(acc_wr, idx, IDX_CTRL_TWO)) begin
      control_two_ff <= pwdata[7:0];
    end
  end

  // status two keeps only its three writable low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_two_ff <= 3'h0;
    end else if (reg_hit(acc_wr, idx, IDX_STAT_TWO)) begin
      status_two_ff <= pwdata[2:0];
    end
  end

  // ninth transmit bit, written through data high before data low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t8_ff <= 1'b0;
    end else if (reg_hit(acc_wr, idx, IDX_DATA_HIGH)) begin
      t8_ff <= pwdata[DRH_T8];
    end
  end

  // generator is armed by the first enable and stays armed until reset
  assign any_enable = control_two_ff[CR2_TX_ON] || control_two_ff[CR2_RX_ON];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_armed_ff <= 1'b0;
    end else if (clk_en && any_enable) begin
      gen_armed_ff <= 1'b1;
    end
  end

  // a zero divisor stops it, whatever the enables say
  assign gen_run = gen_armed_ff && (divisor_value_ff != '0);

  // wrap on reaching or passing the end, so a divisor made smaller
  // mid-count takes hold at once instead of running round all 13 bits
  assign div_wrap = (div_cnt_ff >= divisor_value_ff - 1'b1);

  // module clocks per sixteenth of a bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= '0;
    end else if (clk_en) begin
      if (!gen_run || div_wrap) begin
        div_cnt_ff <= '0;
      end else begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
      end
    end
  end

  // sixteen sample ticks make one bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt_ff <= 4'h0;
    end else if (clk_en) begin
      if (!gen_run) begin
        os_cnt_ff <= 4'h0;
      end else if (div_wrap) begin
        os_cnt_ff <= os_cnt_ff + 4'h1;
      end
    end
  end

  // ticks are one-cycle pulses shared by transmitter and receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else if (clk_en) begin
      sample_tick <= gen_run && div_wrap;
      bit_tick    <= gen_run && div_wrap
                     && (os_cnt_ff == 4'(OVERSAMPLE - 1));
    end
  end

  // transmit pin is a registered copy of the shifter output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin <= 1'b1;
    end else if (clk_en) begin
      tx_pin <= tx_serial;
    end
  end

  // the port owns the pin while transmitting or in single-wire output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_oe <= 1'b0;
    end else if (clk_en) begin
      tx_pin_oe <= control_two_ff[CR2_TX_ON] || status_two_ff[SR2_TXDIR];
    end
  end

  // receive source: the pin normally, else transmitter output or its pin
  always_comb begin
    nxt_rx_serial = rx_pin;
    if (control_one_ff[CR1_LOOP]) begin
      if (control_one_ff[CR1_RECEIVE_SOURCE_SELECT]) begin
        nxt_rx_serial = tx_pin;
      end else begin
        nxt_rx_serial = tx_serial;
      end
    end
  end

  // registered so the receiver input comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_serial <= 1'b1;
    end else if (clk_en) begin
      rx_serial <= nxt_rx_serial;
    end
  end

  // configuration handed to the shifters; no mode inputs exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (clk_en) begin
      cfg.loop_select           <= control_one_ff[CR1_LOOP];
      cfg.receive_source_select <= control_one_ff[CR1_RECEIVE_SOURCE_SELECT];
      cfg.nine_bits             <= control_one_ff[CR1_NINE];
      cfg.parity_on             <= control_one_ff[CR1_PAR_ON];
      cfg.parity_odd_select     <= control_one_ff[CR1_PAR_OD];
      cfg.transmitter_on        <= control_two_ff[CR2_TX_ON];
      cfg.receiver_on           <= control_two_ff[CR2_RX_ON];
    end
  end

  // parity over the loaded word: even is the xor of ones, odd inverts it;
  // the ninth bit of the loaded word counts only in nine-bit format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_parity_even <= 1'b1;
    end else if (clk_en) begin
      tx_parity_even <= ^{tx_word[8] & control_one_ff[CR1_NINE], tx_word[7:0]}
                        ^ control_one_ff[CR1_PAR_OD];
    end
  end

  // transmit word latched with the ninth bit as it stood at the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word <= 9'h000;
    end else if (reg_hit(acc_wr, idx, IDX_DATA_LOW)) begin
      tx_word <= {t8_ff, pwdata[7:0]};
    end
  end

  // one-cycle strobe telling the transmitter a word is waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word_load <= 1'b0;
    end else if (clk_en) begin
      tx_word_load <= reg_hit(acc_wr, idx, IDX_DATA_LOW);
    end
  end

  // one-cycle strobe telling the receiver its word was taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word_read <= 1'b0;
    end else if (clk_en) begin
      rx_word_read <= reg_hit(acc_rd, idx, IDX_DATA_LOW);
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (in_map) begin
      case (idx)
        IDX_BAUD_HIGH: nxt_prdata[4:0] = divisor_value_ff[12:8];
        IDX_BAUD_LOW:  nxt_prdata[7:0] = divisor_value_ff[7:0];
        IDX_CTRL_ONE:  nxt_prdata[7:0] = control_one_ff;
        IDX_CTRL_TWO:  nxt_prdata[7:0] = control_two_ff;
        IDX_STAT_ONE:  nxt_prdata[7:0] = status_one_in;
        IDX_STAT_TWO:  nxt_prdata[2:0] = status_two_ff;
        IDX_DATA_HIGH: nxt_prdata[7:0] = {rx_bit9, t8_ff, 6'h00};
        IDX_DATA_LOW:  nxt_prdata[7:0] = rx_byte;
        default:       nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // answer in the first access cycle, so every transfer takes two cycles;
  // a fixed answer keeps the master simple at the cost of no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= acc_setup;
    end
  end

  // no transfer is ever refused with an error; unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
    end
  end

  // read data captured at the end of setup and held until the next read,
  // so it already stands when the master samples ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc_setup && !pwrite) begin
      prdata <= nxt_prdata;
    end
  end
endmodule

// ---- test/asr_chk.sv ----
// Purpose: port checks on the serial register block
// Assumes: clk_en held high by the bench
// Notes:   bound by name onto every asr_regs
module asr_chk
  import asr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_pin,
  input wire logic        tx_serial,
  input wire logic        tx_pin,
  input wire logic        tx_pin_oe,
  input wire logic        rx_serial,
  input wire logic        sample_tick,
  input wire logic [8:0]  tx_word,
  input wire logic        tx_word_load,
  input wire asr_cfg_t    cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed_ff;
  // remembers a first enable; it is sticky until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) armed_ff <= 1'b0;
    else if (cfg.transmitter_on || cfg.receiver_on) armed_ff <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_low_wr;
    s_acc ##0 pwrite && paddr == 32'h0000001C;
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (s_acc |=> !pready)
    else $error("ready held too long");
  a_no_error: assert property (pready |-> !pslverr)
    else $error("error response seen");
  a_loop_normal: assert property (!cfg.loop_select ##1 !cfg.loop_select |-> rx_serial == $past(rx_pin))
    else $error("receiver not fed from pin");
  a_loop_inner: assert property ((cfg.loop_select && !cfg.receive_source_select)[*2]
    |-> rx_serial == $past(tx_serial))
    else $error("receiver not fed from transmitter");
  a_tx_copy: assert property (tx_pin == $past(tx_serial))
    else $error("pin does not follow transmitter");
  a_oe_follow: assert property (cfg.transmitter_on[*2] |=> tx_pin_oe)
    else $error("pin not driven while transmitter on");
  a_word_load: assert property (s_low_wr |=> tx_word_load
    && {24'h000000, tx_word[7:0]} == ($past(pwdata) & 32'h000000FF))
    else $error("data word not loaded");
  a_gen_idle: assert property (!armed_ff && !cfg.transmitter_on && !cfg.receiver_on |-> !sample_tick)
    else $error("tick before first enable");
endmodule
bind asr_regs asr_chk asr_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
  .tx_serial(tx_serial), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .rx_serial(rx_serial),
  .sample_tick(sample_tick), .tx_word(tx_word), .tx_word_load(tx_word_load), .cfg(cfg)
);

// ---- test/asr_remote.sv ----
// Purpose: remote serial device seen at the two pins
// Assumes: its line is driven high by reset until it sends
// Notes:   sends a rotating pattern, one bit onto the line per cycle
module asr_remote
  import asr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_pin,
  input wire logic tx_pin_oe,
  output logic     rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat_ff;
  // pattern folds in what the port drives, so stale data would show
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_ff <= 8'hB4;
      rx_pin <= 1'b1;
    end else begin
      pat_ff <= {pat_ff[6:0], pat_ff[7] ^ (tx_pin_oe & tx_pin)};
      rx_pin <= pat_ff[7];
    end
  end
endmodule

// ---- test/asr_regs_tb.sv ----
// Purpose: self-checking bench for the serial register block
// Assumes: clk_en tied high, apb answers follow the design
// Notes:   byte address is four times the register index
module asr_regs_tb
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, tx_serial, rx_pin, rx_bit9;
  logic        pready, pslverr, tx_pin, tx_pin_oe, rx_serial, sample_tick, bit_tick, tx_par;
  logic        rx_rd;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  st_in, rx_byte, q;
  logic [8:0]  tx_word;
  asr_cfg_t    cfg;
  int          n_fail, n_checks;
  asr_regs asr_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_one_in(st_in), .rx_pin(rx_pin),
    .tx_serial(tx_serial), .rx_bit9(rx_bit9), .rx_byte(rx_byte), .tx_pin(tx_pin),
    .tx_pin_oe(tx_pin_oe), .rx_serial(rx_serial), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .tx_word(tx_word), .tx_word_load(), .rx_word_read(rx_rd),
    .tx_parity_even(tx_par), .cfg(cfg));
  asr_remote asr_remote_inst (.pclk(pclk), .presetn(presetn), .tx_pin(tx_pin),
    .tx_pin_oe(tx_pin_oe), .rx_pin(rx_pin));
  // clock and a transmitter line that toggles every cycle once out of reset
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (presetn) tx_serial <= ~tx_serial;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic ticks(input int n, output int s);
    s = 0;
    repeat (n) begin
      @(posedge pclk);
      if (sample_tick === 1'b1) s++;
    end
  endtask
  task automatic t_reset();
    int s;
    rc(32'h0, 8'h00);
    rc(32'h4, 8'h04);
    rc(32'h8, 8'h00);
    rc(32'hC, 8'h00);
    ticks(60, s);
    chk(16'(s), 16'h0000);
    xfer(1'b1, 32'h0, 8'hFF);
    rc(32'h0, 8'h00);
    xfer(1'b1, 32'h4, 8'h21);
    rc(32'h0, 8'h1F);
    rc(32'h4, 8'h21);
    $display("reset and baud test done");
  endtask
  task automatic t_regs();
    xfer(1'b1, 32'h20, 8'hFF);
    rc(32'h20, 8'h00);
    xfer(1'b1, 32'h10, 8'h00);
    rc(32'h10, 8'hA5);
    xfer(1'b1, 32'h8, 8'hB3);
    rc(32'h8, 8'hB3);
    xfer(1'b1, 32'hC, 8'h04);
    repeat (20) @(posedge pclk);
    chk(16'(cfg), 16'h007D);
    xfer(1'b1, 32'h8, 8'h80);
    repeat (20) @(posedge pclk);
    $display("register test done");
  endtask
  task automatic t_data();
    xfer(1'b1, 32'h8, 8'h00);
    xfer(1'b1, 32'h18, 8'h00);
    xfer(1'b1, 32'h1C, 8'h5A);
    repeat (3) @(posedge pclk);
    chk({tx_par, 6'h00, tx_word}, 16'h005A);
    xfer(1'b1, 32'h8, 8'h01);
    xfer(1'b1, 32'h1C, 8'h5A);
    repeat (3) @(posedge pclk);
    chk({tx_par, 6'h00, tx_word}, 16'h805A);
    xfer(1'b1, 32'h18, 8'h40);
    xfer(1'b1, 32'h1C, 8'h5A);
    repeat (3) @(posedge pclk);
    chk({7'h00, tx_word}, 16'h015A);
    rc(32'h18, 8'hC0);
    rc(32'h1C, 8'h3C);
    @(posedge pclk);
    chk({15'h0000, rx_rd}, 16'h0001);
    $display("data test done");
  endtask
  task automatic t_rate();
    int c;
    int s;
    c = 0;
    s = 0;
    xfer(1'b1, 32'h0, 8'h00);
    xfer(1'b1, 32'h4, 8'h03);
    xfer(1'b1, 32'hC, 8'h08);
    while (bit_tick !== 1'b1 && c < 400) begin
      @(posedge pclk);
      c++;
    end
    c = 0;
    do begin
      @(posedge pclk);
      c++;
      if (sample_tick === 1'b1) s++;
    end while (bit_tick !== 1'b1 && c < 400);
    chk(16'(c), 16'h0030);
    chk(16'(s), 16'h0010);
    xfer(1'b1, 32'h4, 8'h00);
    repeat (8) @(posedge pclk);
    ticks(100, s);
    chk(16'(s), 16'h0000);
    $display("rate test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #60000;
    n_fail++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    tx_serial = 1'b1;
    rx_bit9 = 1'b1;
    rx_byte = 8'h3C;
    st_in = 8'hA5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_data();
    t_rate();
    end_sim();
  end
endmodule
